/* File: ext_status_asserts.sv */
// Concurrent checks on the loopback, echo, request and BRG ports
`timescale 1ns/1ps
module ext_status_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_bvalid,
  input wire logic        tx_data_int,
  input wire logic        rxd_in,
  input wire logic        txd_out,
  input wire logic        rx_data_out,
  input wire logic        data_strobe_n,
  input wire logic        dtr_req_n_out,
  input wire logic        rx_tx_clock_pin_tick,
  input wire logic        xtal_tick,
  input wire logic        crystal_select_bit,
  input wire logic        brg_src_tick,
  input wire logic        brg_output_enable
);
  logic [4:0] misc;
  logic       dtr;
  logic [1:0] ticks;
  wire take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && s_axi_wstrb[0];
  wire sel_tick = crystal_select_bit ? xtal_tick : rx_tx_clock_pin_tick;
  // Shadow of the control bits, rebuilt from the writes seen on the bus
  always_ff @(posedge aclk) begin
    if (!aresetn) misc <= 5'h00;
    else if (take && s_axi_awaddr == 8'h00) misc <= s_axi_wdata[4:0];
    else if (take && s_axi_awaddr == 8'h0c && s_axi_wdata[3])
      misc[4:2] <= 3'h0;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) dtr <= 1'b0;
    else if (take && s_axi_awaddr == 8'h14) dtr <= s_axi_wdata[1];
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !misc[0]) ticks <= 2'h0;
    else if (brg_src_tick && ticks != 2'h3) ticks <= ticks + 2'h1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence strobe_fall;
    $fell(data_strobe_n) && misc[2] && !dtr_req_n_out;
  endsequence
  chk_loop_rx: assert property (
    misc[4] |=> rx_data_out == $past(tx_data_int))
    else $error("receiver not fed from transmitter in loopback");
  chk_rx_direct: assert property (
    !misc[4] |=> rx_data_out == $past(rxd_in))
    else $error("receiver not fed from data pin");
  chk_echo_tx: assert property (
    misc[3] |=> txd_out == $past(rxd_in))
    else $error("transmit pin not echoing receive pin");
  chk_tx_normal: assert property (
    !misc[3] |=> txd_out == $past(tx_data_int))
    else $error("transmit pin not carrying transmit data");
  chk_dtr_follow: assert property (
    !misc[2] |=> dtr_req_n_out == !$past(dtr))
    else $error("terminal-ready pin not following its bit");
  chk_req_hold: assert property (
    strobe_fall |=> !dtr_req_n_out [*2])
    else $error("request released too early after strobe");
  chk_src_pclk: assert property (
    misc[1] |=> brg_src_tick)
    else $error("generator not ticking from clock");
  chk_src_pin: assert property (
    !misc[1] |=> brg_src_tick == $past(sel_tick))
    else $error("generator tick not from pin or crystal");
  chk_brg_sync: assert property (
    brg_output_enable |-> ticks >= 2'h2)
    else $error("generator output before two counts");
  chk_brg_stop: assert property (
    !misc[0] |=> !brg_output_enable)
    else $error("generator output not stopped at once");
endmodule : ext_status_asserts
bind ext_status_irq_and_loopback_ctrl ext_status_asserts i_chk (.*);

/* File: ext_status_defs.svh */
// Register offsets, field positions, reset values and timing counts
// How it works
// - Loopback sends transmit data to receiver and pin; enables ignored, interrupts kept.
// - Loopback works in all modes but Loop; channel or hardware reset clears it.
// - Auto echo drives transmit pin from receive pin; transmit enable ignored.
// - Request function: pin follows terminal-ready bit, or requests on buffer empty/CRC.
// - Request held until three to four clocks after the data strobe falls.
// - Baud generator source: pin or crystal when 0, peripheral clock when 1.
// - Generator enable shows at output after two counts; disable is immediate.
// - Source enables need group enable; only changes after enabling interrupt.
// - Break/abort enable: any break/abort change interrupts; reset sets enable.
// - Underrun/message-end enable: latch rising interrupts; reset sets enable.
// - Clear-to-send enable: pin change interrupts; reset sets enable.
// - Sync/hunt enable: sync pin in async, hunt bit in sync modes.
// - Carrier-detect enable: pin change interrupts; reset sets enable.
// - Zero-count enable: each generator zero interrupts; reset clears enable.
// - Async break status sets on null with framing error, clears at break end.
// - SDLC abort status sets on seven ones, clears when sequence ends.
// - Both break/abort edges interrupt even while another interrupt pends.
// - Underrun latch set by resets, disable, send abort, underrun; one command clears.
// - Only underrun latch rising interrupts; send abort re-sets it.
// - Clear-to-send status latched while enabled, odd changes re-interrupt, else live.
`ifndef EXT_STATUS_DEFS_SVH
`define EXT_STATUS_DEFS_SVH

`define ADDR_MISC_CONTROL   8'h00
`define ADDR_IRQ_ENABLE     8'h04
`define ADDR_BUF_EXT_STATUS 8'h08
`define ADDR_COMMAND        8'h0c
`define ADDR_GROUP_CONTROL  8'h10
`define ADDR_TX_CONTROL     8'h14
`define ADDR_MODE_CONTROL   8'h18

`define MISC_LOOPBACK   4
`define MISC_AUTO_ECHO  3
`define MISC_REQ_FUNC   2
`define MISC_BRG_SRC    1
`define MISC_BRG_EN     0

`define IE_BREAK    7
`define IE_UNDERRUN 6
`define IE_CTS      5
`define IE_SYNC     4
`define IE_DCD      3
`define IE_ZERO     1
`define IE_RESET    8'hf8

`define ST_BREAK    7
`define ST_UNDERRUN 6
`define ST_CTS      5
`define ST_SYNC     4
`define ST_DCD      3
`define ST_TXEMPTY  2
`define ST_ZERO     1
`define ST_RXAVAIL  0

`define CMD_RESET_EXT      0
`define CMD_SEND_ABORT     1
`define CMD_RESET_UNDERRUN 2
`define CMD_CHANNEL_RESET  3

`define GRP_EXT_IE    0
`define TXC_TX_ENABLE 0
`define TXC_DTR       1
`define MODE_AUTO_EN  2

`define ABORT_ONES     7
`define BRG_SYNC_COUNTS 2
`define REQ_DONE_CYCLES 3

`define RESP_OKAY   2'b00
`define RESP_SLVERR 2'b10

`endif

/* File: ext_status_irq_and_loopback_ctrl.sv */
// Channel external/status interrupts, loopback, echo, request and BRG control
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "ext_status_defs.svh"
module ext_status_irq_and_loopback_ctrl (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        tx_data_int,
  input  wire logic        rxd_in,
  output logic             txd_out,
  output logic             rx_data_out,
  input  wire logic        rx_bit_strobe,
  input  wire logic        rx_null_frame_err,
  input  wire logic        rx_break_end,
  input  wire logic        rx_char_avail,
  input  wire logic        hunt_in,
  input  wire logic        tx_underrun,
  input  wire logic        tx_buffer_empty,
  input  wire logic        crc_sent,
  input  wire logic        cts_n_in,
  input  wire logic        carrier_detect_n_in,
  input  wire logic        sync_n_in,
  input  wire logic        data_strobe_n,
  output logic             dtr_req_n_out,
  output logic             tx_enable_gate,
  output logic             rx_enable_gate,
  input  wire logic        rx_tx_clock_pin_tick,
  input  wire logic        xtal_tick,
  input  wire logic        crystal_select_bit,
  input  wire logic        brg_zero_count,
  output logic             brg_src_tick,
  output logic             brg_count_enable,
  output logic             brg_output_enable,
  output logic             ext_status_irq
);

  logic [7:0]                misc_control;
  logic [7:0]                external_status_irq_enable;
  logic                      group_ext_ie;
  logic [1:0]                tx_control;
  ext_status_pkg::mode_t     mode;
  logic                      auto_enables;
  logic                      wr_fire;
  logic                      rd_fire;
  logic                      wr_hit;
  logic [7:0]                wbyte;
  logic                      chan_reset;
  logic                      cmd_reset_ext;
  logic                      cmd_send_abort;
  logic                      cmd_reset_underrun;
  logic [7:0]                next_ie;
  logic [7:0]                ie_rise;
  logic                      async_mode;
  logic                      loop_active;

  // Bus handshake: write address and data are taken together
  assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign rd_fire       = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = rd_fire;
  assign wbyte         = s_axi_wdata[7:0];
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `ADDR_MISC_CONTROL) || (a == `ADDR_IRQ_ENABLE) ||
             (a == `ADDR_BUF_EXT_STATUS) || (a == `ADDR_COMMAND) ||
             (a == `ADDR_GROUP_CONTROL) || (a == `ADDR_TX_CONTROL) ||
             (a == `ADDR_MODE_CONTROL);
  endfunction : mapped
  function automatic logic wr_to(input logic [7:0] a, input logic [7:0] o);
    wr_to = (a == o);
  endfunction : wr_to
  assign wr_hit = wr_fire && s_axi_wstrb[0];

  assign chan_reset = wr_hit && wr_to(s_axi_awaddr, `ADDR_COMMAND) &&
                      wbyte[`CMD_CHANNEL_RESET];
  assign cmd_reset_ext = wr_hit && wr_to(s_axi_awaddr, `ADDR_COMMAND) &&
                         wbyte[`CMD_RESET_EXT];
  assign cmd_send_abort = wr_hit && wr_to(s_axi_awaddr, `ADDR_COMMAND) &&
                          wbyte[`CMD_SEND_ABORT];
  assign cmd_reset_underrun = wr_hit && wr_to(s_axi_awaddr, `ADDR_COMMAND) &&
                              wbyte[`CMD_RESET_UNDERRUN];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (mapped(s_axi_awaddr) &&
                       !wr_to(s_axi_awaddr, `ADDR_BUF_EXT_STATUS)) ?
                      `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Channel-reset bits of the misc register; source and enable need hardware
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      misc_control <= 8'h00;
    end else if (wr_hit && wr_to(s_axi_awaddr, `ADDR_MISC_CONTROL)) begin
      misc_control <= {3'h0, wbyte[4:0]};
    end else if (chan_reset) begin
      misc_control[`MISC_LOOPBACK]  <= 1'b0;
      misc_control[`MISC_AUTO_ECHO] <= 1'b0;
      misc_control[`MISC_REQ_FUNC]  <= 1'b0;
    end
  end

  always_comb begin
    next_ie = external_status_irq_enable;
    if (wr_hit && wr_to(s_axi_awaddr, `ADDR_IRQ_ENABLE)) begin
      next_ie = wbyte;
    end else if (chan_reset) begin
      next_ie = `IE_RESET;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      external_status_irq_enable <= `IE_RESET;
    end else begin
      external_status_irq_enable <= next_ie;
    end
  end

  // An enable that turns on discards changes from before it
  assign ie_rise = next_ie & ~external_status_irq_enable;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      group_ext_ie <= 1'b0;
      tx_control   <= 2'h0;
      mode         <= ext_status_pkg::MODE_ASYNC;
      auto_enables <= 1'b0;
    end else if (wr_hit) begin
      if (wr_to(s_axi_awaddr, `ADDR_GROUP_CONTROL)) begin
        group_ext_ie <= wbyte[`GRP_EXT_IE];
      end
      if (wr_to(s_axi_awaddr, `ADDR_TX_CONTROL)) begin
        tx_control <= wbyte[1:0];
      end
      if (wr_to(s_axi_awaddr, `ADDR_MODE_CONTROL)) begin
        mode         <= ext_status_pkg::mode_t'(wbyte[1:0]);
        auto_enables <= wbyte[`MODE_AUTO_EN];
      end
    end
  end

  assign async_mode  = (mode == ext_status_pkg::MODE_ASYNC);
  assign loop_active = misc_control[`MISC_LOOPBACK] &&
                       (mode != ext_status_pkg::MODE_LOOP);

  // Data routing for loopback and echo
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd_out     <= 1'b1;
      rx_data_out <= 1'b1;
    end else begin
      txd_out     <= misc_control[`MISC_AUTO_ECHO] ? rxd_in :
                     tx_data_int;
      rx_data_out <= loop_active ? tx_data_int : rxd_in;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_enable_gate <= 1'b0;
      rx_enable_gate <= 1'b0;
    end else begin
      tx_enable_gate <= loop_active || misc_control[`MISC_AUTO_ECHO] ||
                        !auto_enables || !cts_n_in;
      rx_enable_gate <= loop_active || !auto_enables ||
                        !carrier_detect_n_in;
    end
  end

  // Request pin
  logic       req_active;
  logic       strobe_prev;
  logic       empty_prev;
  logic       req_timing;
  logic [2:0] req_count;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_prev <= 1'b1;
      empty_prev  <= 1'b1;
    end else begin
      strobe_prev <= data_strobe_n;
      empty_prev  <= tx_buffer_empty;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_active <= 1'b0;
      req_timing <= 1'b0;
      req_count  <= 3'h0;
    end else if ((tx_buffer_empty && !empty_prev) ||
                 (!async_mode && crc_sent)) begin
      req_active <= 1'b1;
      req_timing <= 1'b0;
      req_count  <= 3'h0;
    end else if (req_timing) begin
      if (req_count == 3'(`REQ_DONE_CYCLES - 1)) begin
        req_active <= 1'b0;
        req_timing <= 1'b0;
      end else begin
        req_count <= req_count + 3'h1;
      end
    end else if (req_active && strobe_prev && !data_strobe_n) begin
      req_timing <= 1'b1;
      req_count  <= 3'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dtr_req_n_out <= 1'b1;
    end else begin
      dtr_req_n_out <= misc_control[`MISC_REQ_FUNC] ? !req_active :
                       !tx_control[`TXC_DTR];
    end
  end

  // Baud generator source and synchronised enable
  logic [1:0] brg_sync;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brg_src_tick <= 1'b0;
    end else begin
      brg_src_tick <= misc_control[`MISC_BRG_SRC] ? 1'b1 :
                      (crystal_select_bit ? xtal_tick :
                       rx_tx_clock_pin_tick);
    end
  end

  assign brg_count_enable = misc_control[`MISC_BRG_EN];
  always_ff @(posedge aclk) begin
    if (!aresetn || !misc_control[`MISC_BRG_EN]) begin
      brg_sync          <= 2'h0;
      brg_output_enable <= 1'b0;
    end else if (brg_src_tick && !brg_output_enable) begin
      if (brg_sync == 2'(`BRG_SYNC_COUNTS - 1)) begin
        brg_output_enable <= 1'b1;
      end
      brg_sync <= brg_sync + 2'h1;
    end
  end

  // Break/abort status
  logic       brk_status;
  logic [2:0] ones_run;

  always_ff @(posedge aclk) begin
    if (!aresetn || chan_reset) begin
      brk_status <= 1'b0;
      ones_run   <= 3'h0;
    end else if (mode == ext_status_pkg::MODE_SDLC) begin
      if (rx_bit_strobe) begin
        if (!rx_data_out) begin
          ones_run   <= 3'h0;
          brk_status <= 1'b0;
        end else if (ones_run == 3'(`ABORT_ONES - 1)) begin
          brk_status <= 1'b1;
        end else begin
          ones_run <= ones_run + 3'h1;
        end
      end
    end else if (async_mode) begin
      if (rx_null_frame_err) begin
        brk_status <= 1'b1;
      end else if (rx_break_end) begin
        brk_status <= 1'b0;
      end
    end
  end

  // Underrun/message-end latch
  logic underrun_latch;
  logic tx_en_prev;
  logic underrun_set;

  assign underrun_set = tx_underrun || cmd_send_abort ||
                        (tx_en_prev && !tx_control[`TXC_TX_ENABLE]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_en_prev <= 1'b0;
    end else begin
      tx_en_prev <= tx_control[`TXC_TX_ENABLE];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || chan_reset) begin
      underrun_latch <= 1'b1;
    end else if (underrun_set) begin
      underrun_latch <= 1'b1;
    end else if (cmd_reset_underrun) begin
      underrun_latch <= 1'b0;
    end
  end

  // External/status latches and pending flag
  logic ext_pending;
  logic brk_prev;
  logic und_prev;
  logic cts_lat;
  logic dcd_lat;
  logic sync_lat;
  logic cts_live;
  logic dcd_live;
  logic sync_live;
  logic [7:0] ie_eff;
  logic ev_change;
  logic ev_brk;
  logic ev_und;
  logic ev_zero;

  assign cts_live  = !cts_n_in;
  assign dcd_live  = !carrier_detect_n_in;
  assign sync_live = async_mode ? !sync_n_in : hunt_in;
  assign ie_eff    = group_ext_ie ? external_status_irq_enable : 8'h00;

  // Live-versus-latched comparison only while nothing is pending
  assign ev_change = !ext_pending && (
    (ie_eff[`IE_CTS]  && !ie_rise[`IE_CTS]  && cts_live  != cts_lat) ||
    (ie_eff[`IE_DCD]  && !ie_rise[`IE_DCD]  && dcd_live  != dcd_lat) ||
    (ie_eff[`IE_SYNC] && !ie_rise[`IE_SYNC] &&
     sync_live != sync_lat));
  assign ev_brk  = ie_eff[`IE_BREAK] && (brk_status != brk_prev);
  assign ev_und  = ie_eff[`IE_UNDERRUN] && underrun_latch &&
                   !und_prev;
  assign ev_zero = ie_eff[`IE_ZERO] && brg_zero_count;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brk_prev <= 1'b0;
      und_prev <= 1'b1;
    end else begin
      brk_prev <= brk_status;
      und_prev <= underrun_latch;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || chan_reset) begin
      ext_pending <= 1'b0;
    end else if (ev_change || ev_brk || ev_und || ev_zero) begin
      ext_pending <= 1'b1;
    end else if (cmd_reset_ext) begin
      ext_pending <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || chan_reset) begin
      cts_lat  <= 1'b0;
      dcd_lat  <= 1'b0;
      sync_lat <= 1'b0;
    end else if (!ext_pending || ie_rise != 8'h00) begin
      // Track while idle; a new enable reloads so old changes are dropped
      if (!ext_pending || ie_rise[`IE_CTS]) begin
        cts_lat <= cts_live;
      end
      if (!ext_pending || ie_rise[`IE_DCD]) begin
        dcd_lat <= dcd_live;
      end
      if (!ext_pending || ie_rise[`IE_SYNC]) begin
        sync_lat <= sync_live;
      end
    end
  end

  assign ext_status_irq = ext_pending && group_ext_ie;
  // Read path
  logic [7:0] status_byte;

  always_comb begin
    status_byte = 8'h00;
    status_byte[`ST_BREAK]    = brk_status;
    status_byte[`ST_UNDERRUN] = underrun_latch;
    status_byte[`ST_CTS]      = external_status_irq_enable[`IE_CTS] ?
                                cts_lat : cts_live;
    status_byte[`ST_SYNC]     = external_status_irq_enable[`IE_SYNC] ?
                                sync_lat : sync_live;
    status_byte[`ST_DCD]      = external_status_irq_enable[`IE_DCD] ?
                                dcd_lat : dcd_live;
    status_byte[`ST_TXEMPTY]  = tx_buffer_empty;
    status_byte[`ST_ZERO]     = external_status_irq_enable[`IE_ZERO] &&
                                brg_zero_count;
    status_byte[`ST_RXAVAIL]  = rx_char_avail;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      unique case (s_axi_araddr)
        `ADDR_MISC_CONTROL:   s_axi_rdata <= {24'h0, misc_control};
        `ADDR_IRQ_ENABLE:     s_axi_rdata <= {24'h0,
                                              external_status_irq_enable};
        `ADDR_BUF_EXT_STATUS: s_axi_rdata <= {24'h0, status_byte};
        `ADDR_GROUP_CONTROL:  s_axi_rdata <= {31'h0, group_ext_ie};
        `ADDR_TX_CONTROL:     s_axi_rdata <= {30'h0, tx_control};
        `ADDR_MODE_CONTROL:   s_axi_rdata <= {29'h0, auto_enables, mode};
        default:              s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : ext_status_irq_and_loopback_ctrl

/* File: ext_status_pkg.sv */
// Types shared by the external/status and loopback control block
package ext_status_pkg;
  typedef enum logic [1:0] {
    MODE_ASYNC = 2'b00,
    MODE_SYNC  = 2'b01,
    MODE_SDLC  = 2'b10,
    MODE_LOOP  = 2'b11
  } mode_t;
endpackage : ext_status_pkg

/* File: line_model.sv */
// Far-side model of the serial data pin and the modem-control pins
`timescale 1ns/1ps
module line_model (
  input  wire logic aclk,
  input  wire logic cts_lvl,
  input  wire logic dcd_lvl,
  output logic      rxd_in,
  output logic      cts_n_in,
  output logic      carrier_detect_n_in,
  output logic      sync_n_in
);
  initial begin
    {rxd_in, cts_n_in, carrier_detect_n_in, sync_n_in} = 4'hf;
  end
  // Line data is drawn at random every cycle so a stale bit matches only by chance
  always @(posedge aclk) begin
    rxd_in              <= 1'($urandom);
    cts_n_in            <= cts_lvl;
    carrier_detect_n_in <= dcd_lvl;
    sync_n_in           <= 1'b1;
  end
endmodule : line_model

/* File: testbench.sv */
// Self-checking bench for the external/status and loopback control block
`timescale 1ns/1ps
module testbench;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        tx_data_int, rxd_in, txd_out, rx_data_out, rx_bit_strobe;
  logic        rx_null_frame_err, rx_break_end, rx_char_avail, hunt_in;
  logic        tx_underrun, tx_buffer_empty, crc_sent, cts_n_in, sync_n_in;
  logic        carrier_detect_n_in, data_strobe_n, dtr_req_n_out;
  logic        tx_enable_gate, rx_enable_gate, rx_tx_clock_pin_tick;
  logic        xtal_tick, crystal_select_bit, brg_zero_count, brg_src_tick;
  logic        brg_count_enable, brg_output_enable, ext_status_irq;
  logic        cts_lvl, dcd_lvl;
  logic [2:0]  ev;
  int          miscompares, checks_done, cycles, n;
  assign {tx_underrun, rx_break_end, rx_null_frame_err} = ev;
  ext_status_irq_and_loopback_ctrl i_dut (.*);
  line_model i_line (.*);
  function automatic logic req_ok(int c);
    return c >= 3 && c <= 6;
  endfunction : req_ok
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic tick(int c);
    repeat (c) @(posedge aclk);
  endtask : tick
  task automatic wr(logic [7:0] a, logic [7:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    do @(posedge aclk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
  endtask : wr
  task automatic rd(logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask : rd
  task automatic st(logic [2:0] e);
    rd(8'h08);
    chk("status_hi", e, rdv[7:5]);
  endtask : st
  task automatic pulse(int i);
    ev[i] <= 1'b1;
    @(posedge aclk);
    ev[i] <= 1'b0;
    tick(3);
  endtask : pulse
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles > 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  always @(posedge aclk) begin
    tx_data_int          <= 1'($urandom);
    rx_bit_strobe        <= 1'($urandom);
    rx_char_avail        <= 1'($urandom);
    crc_sent             <= 1'($urandom);
    rx_tx_clock_pin_tick <= 1'($urandom);
    xtal_tick            <= 1'($urandom);
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, ev} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h3f;
    {tx_data_int, rx_bit_strobe, rx_char_avail, crc_sent} = '0;
    {rx_tx_clock_pin_tick, xtal_tick, hunt_in, brg_zero_count} = '0;
    {tx_buffer_empty, data_strobe_n, cts_lvl, dcd_lvl} = 4'h7;
    {miscompares, checks_done, cycles} = '0;
    void'($urandom(88));
    crystal_select_bit = 1'($urandom);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    st(3'h2);
    rd(8'h1c);
    chk("unmapped_resp", 2'h2, rsp);
    chk("unmapped_data", 32'h0, rdv);
    wr(8'h08, 8'hff);
    chk("status_write_resp", 2'h2, rsp);
    $display("test registers done");
    wr(8'h18, 8'h04);
    tick(2);
    chk("tx_gate_off", 1'b0, tx_enable_gate);
    wr(8'h00, 8'h10);
    tick(8);
    chk("rx_gate_loop", 1'b1, rx_enable_gate);
    wr(8'h00, 8'h18);
    tick(8);
    chk("tx_gate_echo", 1'b1, tx_enable_gate);
    wr(8'h0c, 8'h08);
    tick(8);
    $display("test loopback done");
    wr(8'h10, 8'h01);
    tick(2);
    chk("irq_idle", 1'b0, ext_status_irq);
    pulse(0);
    chk("irq_break_set", 1'b1, ext_status_irq);
    st(3'h6);
    wr(8'h0c, 8'h01);
    tick(2);
    chk("irq_cleared", 1'b0, ext_status_irq);
    pulse(1);
    chk("irq_break_end", 1'b1, ext_status_irq);
    st(3'h2);
    wr(8'h0c, 8'h01);
    wr(8'h0c, 8'h04);
    chk("irq_underrun_fall", 1'b0, ext_status_irq);
    st(3'h0);
    wr(8'h0c, 8'h02);
    tick(2);
    chk("irq_send_abort", 1'b1, ext_status_irq);
    st(3'h2);
    wr(8'h0c, 8'h01);
    pulse(2);
    chk("irq_underrun_held", 1'b0, ext_status_irq);
    wr(8'h0c, 8'h04);
    pulse(2);
    chk("irq_underrun", 1'b1, ext_status_irq);
    wr(8'h0c, 8'h01);
    wr(8'h04, 8'hb8);
    wr(8'h0c, 8'h04);
    wr(8'h0c, 8'h02);
    tick(2);
    chk("irq_underrun_off", 1'b0, ext_status_irq);
    wr(8'h04, 8'hf8);
    tick(2);
    chk("irq_no_stale", 1'b0, ext_status_irq);
    $display("test break and underrun done");
    cts_lvl <= 1'b0;
    tick(4);
    chk("irq_cts", 1'b1, ext_status_irq);
    st(3'h3);
    cts_lvl <= 1'b1;
    tick(3);
    cts_lvl <= 1'b0;
    tick(3);
    wr(8'h0c, 8'h01);
    tick(3);
    chk("irq_cts_even", 1'b0, ext_status_irq);
    cts_lvl <= 1'b1;
    tick(4);
    chk("irq_cts_rise", 1'b1, ext_status_irq);
    cts_lvl <= 1'b0;
    tick(3);
    wr(8'h0c, 8'h01);
    tick(3);
    chk("irq_cts_odd", 1'b1, ext_status_irq);
    wr(8'h0c, 8'h01);
    wr(8'h04, 8'hd8);
    cts_lvl <= 1'b1;
    tick(4);
    chk("irq_cts_off", 1'b0, ext_status_irq);
    st(3'h2);
    wr(8'h04, 8'hf8);
    dcd_lvl <= 1'b0;
    tick(4);
    chk("irq_dcd", 1'b1, ext_status_irq);
    wr(8'h0c, 8'h01);
    wr(8'h10, 8'h00);
    dcd_lvl <= 1'b1;
    tick(4);
    chk("irq_group_off", 1'b0, ext_status_irq);
    $display("test modem status done");
    wr(8'h14, 8'h02);
    tick(2);
    chk("dtr_on", 1'b0, dtr_req_n_out);
    wr(8'h14, 8'h00);
    wr(8'h00, 8'h04);
    tick(2);
    chk("req_idle", 1'b1, dtr_req_n_out);
    tx_buffer_empty <= 1'b0;
    tick(2);
    tx_buffer_empty <= 1'b1;
    tick(4);
    chk("req_active", 1'b0, dtr_req_n_out);
    data_strobe_n   <= 1'b0;
    tx_buffer_empty <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (dtr_req_n_out !== 1'b1 && n < 12);
    data_strobe_n <= 1'b1;
    chk("req_release", 1'b1, req_ok(n));
    $display("test request done");
    wr(8'h00, 8'h03);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (brg_output_enable !== 1'b1 && n < 20);
    chk("brg_out", 1'b1, brg_output_enable);
    chk("brg_late", 1'b1, n >= 2);
    chk("brg_count", 1'b1, brg_count_enable);
    wr(8'h00, 8'h00);
    tick(1);
    chk("brg_stop", 1'b0, brg_output_enable);
    wr(8'h00, 8'h01);
    tick(30);
    repeat (16) begin
      wr(8'h00, 8'($urandom) & 8'h1f);
      tick(4);
    end
    $display("test generator and random done");
    tally_and_finish();
  end
endmodule : testbench
